// [design/dsss_pkg.sv]
/*
 * Constants and state types of the drive start/stop sequencer.
 * Assumes a 25 MHz core clock; frequencies in 0.1 Hz units, times in 0.1 s units.
 */
package dsss_pkg;
	localparam int unsigned CLK_HZ          = 25_000_000;
	localparam int unsigned TENTH_S_NS      = 100_000_000;
	localparam int unsigned CLK_PERIOD_NS   = 1_000_000_000 / CLK_HZ;
	localparam int unsigned TENTH_S_CYCLES  = TENTH_S_NS / CLK_PERIOD_NS;
	localparam int unsigned FREQ_W          = 13;
	localparam int unsigned TIME_W          = 16;
	localparam int unsigned PCT_W           = 8;
	localparam logic [1:0]  RAMP_SET_ONE    = 2'h0;
	localparam logic [1:0]  RAMP_SET_FOUR   = 2'h3;
	localparam logic        REV_PERMIT_RST  = 1'h1;
	localparam logic [PCT_W-1:0] TRACK_ILIM_RST = 8'h96;
	localparam logic [FREQ_W-1:0] LAUNCH_RST = 13'h0005;
	localparam logic [PCT_W-1:0] DCB_LEVEL_RST = 8'h14;
	localparam logic [FREQ_W-1:0] FREQ_LIM_MIN = 13'h0001;
	localparam logic [FREQ_W-1:0] FREQ_LIM_MAX = 13'h0064;
	localparam logic [7:0]  TRACK_TIME_MIN  = 8'h01;
	localparam logic [7:0]  TRACK_TIME_MAX  = 8'hc8;
	localparam logic [PCT_W-1:0] TRACK_ILIM_MAX = 8'hc8;
	localparam logic [PCT_W-1:0] DCB_LEVEL_MAX = 8'hc8;
	localparam logic [1:0]  SRC_TERMINAL    = 2'h1;
	localparam logic [1:0]  SRC_COMM        = 2'h2;

	typedef enum logic [2:0] {
		DSSS_IDLE,
		DSSS_START_DCB,
		DSSS_TRACK,
		DSSS_RUN,
		DSSS_DECEL,
		DSSS_HALT_DCB
	} dsss_state_t;
endpackage : dsss_pkg

// [design/dsss_ramp_if.sv]
/*
 * Interface between sequencer and ramp stepper.
 * Assumes both ends share core_clk_in.
 */
`timescale 1ns/10ps
`default_nettype none
interface dsss_ramp_if;
	logic [15:0] ramp_time;
	logic [12:0] full_scale;
	logic [12:0] target;
	logic        load;
	logic [12:0] load_value;
	logic        fast;
	logic [12:0] freq;
	logic        at_target;

	modport seq (output ramp_time, full_scale, target, load, load_value, fast, input freq, at_target);
	modport ramp (input ramp_time, full_scale, target, load, load_value, fast, output freq, at_target);
endinterface : dsss_ramp_if
`default_nettype wire

// [design/dsss_ramp.sv]
/*
 * Frequency ramp stepper: moves the commanded frequency toward target.
 * Assumes ramp time in 0.1 s units, full-scale in 0.1 Hz units.
 */
`timescale 1ns/10ps
`default_nettype none
module dsss_ramp (
	// Clock and reset
	input  wire logic core_clk_in,
	input  wire logic resetn_in,
	// Ramp link
	dsss_ramp_if.ramp rp
);
	// ==========================================================
	// Step timing
	logic [47:0] acc_q;
	logic [47:0] acc_d;
	logic [47:0] period;
	logic        tick;
	logic [12:0] freq_q;

	assign period = rp.fast ? 48'h1 :
		(48'(rp.ramp_time) * 48'(dsss_pkg::TENTH_S_CYCLES)) / 48'(rp.full_scale == 13'h0 ? 13'h1 : rp.full_scale);
	assign tick   = (acc_q + 48'h1 >= period);
	assign acc_d  = tick ? 48'h0 : acc_q + 48'h1;
	assign rp.freq = freq_q;
	assign rp.at_target = (freq_q == rp.target);

	always_ff @(posedge core_clk_in) begin
		if (!resetn_in) begin
			acc_q  <= 48'h0;
			freq_q <= 13'h0;
		end else if (rp.load) begin
			acc_q  <= 48'h0;
			freq_q <= rp.load_value;
		end else begin
			acc_q <= acc_d;
			if (tick && freq_q < rp.target) freq_q <= freq_q + 13'h1; // [RL20]
			else if (tick && freq_q > rp.target) freq_q <= freq_q - 13'h1; // [RL20]
		end
	end
endmodule : dsss_ramp
`default_nettype wire

// [design/dsss_sequencer.sv]
/*
 * Drive start/stop sequencer: ramp set choice, direction permit, panel halt,
 * start by launch frequency or tracking, halt by deceleration or coasting.
 * Assumes configuration ports are static or from core_clk_in logic; run,
 * jog, direction, halt key and current-high inputs come from pins.
 */
//
// Function
// [RL1] Four ramp sets, one applied per ramp
// [RL2] Terminals or step sequencer pick sets two-four
// [RL3] Ramp set one by default
// [RL4] Jogging always uses ramp set four
// [RL5] Reverse permit gates reverse rotation
// [RL6] Panel halt key only for sources 1,2
// [RL7] Run must drop before restart after halt
// [RL8] Method 0: optional DC brake, then launch
// [RL9] Method 1: sweep down fast from set
// [RL10] After tracking, accelerate to set frequency
// [RL11] Track current limit 0-200, reset 150
// [RL12] Overcurrent while tracking lowers frequency
// [RL13] Method 0 halt: decel, then coast or brake
// [RL14] Halt method 1 coasts, no braking
// [RL15] Launch frequency range, clamp to upper limit
// [RL16] Halt frequency ends deceleration
// [RL17] Start brake only with start method 0
// [RL18] Halt brake only with halt method 0
// [RL19] Brake level 0-20 percent, both ends; code clamps the level at 200 (DCB_LEVEL_MAX)
// [RL20] Ramp steps at full-scale per ramp time
`timescale 1ns/10ps
`default_nettype none
module dsss_sequencer #(
	parameter int unsigned TENTH_CYC = dsss_pkg::TENTH_S_CYCLES
) (
	// Clock and reset
	input  wire logic        core_clk_in,
	input  wire logic        resetn_in,
	// Run commands (pins)
	input  wire logic        run_cmd_in,
	input  wire logic        reverse_req_in,
	input  wire logic        jog_in,
	input  wire logic        panel_halt_key_in,
	input  wire logic        current_high_in,
	// Configuration
	input  wire logic [1:0]  command_source_select_in,
	input  wire logic        reverse_permit_in,
	input  wire logic        panel_halt_key_enable_in,
	input  wire logic        start_method_in,
	input  wire logic        halt_method_in,
	input  wire logic [12:0] launch_frequency_in,
	input  wire logic [12:0] halt_frequency_in,
	input  wire logic [7:0]  start_dc_brake_time_in,
	input  wire logic [7:0]  halt_dc_brake_time_in,
	input  wire logic [7:0]  dc_brake_voltage_level_in,
	input  wire logic [7:0]  track_duration_in,
	input  wire logic [7:0]  track_current_limit_in,
	input  wire logic [12:0] set_frequency_in,
	input  wire logic [12:0] max_frequency_in,
	input  wire logic [12:0] upper_limit_in,
	input  wire logic [15:0] ramp_time_set_in [4],
	input  wire logic [1:0]  terminal_ramp_sel_in,
	input  wire logic        step_seq_active_in,
	input  wire logic [1:0]  step_seq_ramp_sel_in,
	// Motor drive outputs
	output var  logic [12:0] out_frequency_out,
	output var  logic        out_enable_out,
	output var  logic        reverse_out,
	output var  logic        dc_brake_out,
	output var  logic [7:0]  dc_brake_level_out,
	output var  logic [7:0]  track_current_limit_out,
	output var  logic [1:0]  ramp_set_out,
	output var  logic        running_out
);
	// ==========================================================
	// Pin synchronisers
	logic [4:0] s1_q;
	logic [4:0] s2_q;
	always_ff @(posedge core_clk_in) begin
		if (!resetn_in) begin
			s1_q <= 5'h0;
			s2_q <= 5'h0;
		end else begin
			s1_q <= {current_high_in, panel_halt_key_in, jog_in, reverse_req_in, run_cmd_in};
			s2_q <= s1_q;
		end
	end
	logic run_s, rev_s, jog_s, key_s, ihigh_s;
	assign {ihigh_s, key_s, jog_s, rev_s, run_s} = s2_q;

	// ==========================================================
	// Parameter clamps
	logic [12:0] launch_f, halt_f, top_f, launch_c;
	logic [7:0]  track_t, ilim, dcb_lvl;
	assign launch_f = launch_frequency_in < dsss_pkg::FREQ_LIM_MIN ? dsss_pkg::FREQ_LIM_MIN :
		launch_frequency_in > dsss_pkg::FREQ_LIM_MAX ? dsss_pkg::FREQ_LIM_MAX : launch_frequency_in; // [RL15]
	assign halt_f = halt_frequency_in < dsss_pkg::FREQ_LIM_MIN ? dsss_pkg::FREQ_LIM_MIN :
		halt_frequency_in > dsss_pkg::FREQ_LIM_MAX ? dsss_pkg::FREQ_LIM_MAX : halt_frequency_in; // [RL16]
	assign top_f = max_frequency_in < upper_limit_in ? max_frequency_in : upper_limit_in; // [RL15]
	assign launch_c = launch_f > top_f ? top_f : launch_f;
	assign track_t = track_duration_in < dsss_pkg::TRACK_TIME_MIN ? dsss_pkg::TRACK_TIME_MIN :
		track_duration_in > dsss_pkg::TRACK_TIME_MAX ? dsss_pkg::TRACK_TIME_MAX : track_duration_in; // [RL10]
	assign ilim = track_current_limit_in > dsss_pkg::TRACK_ILIM_MAX ?
		dsss_pkg::TRACK_ILIM_MAX : track_current_limit_in; // [RL11]
	assign dcb_lvl = dc_brake_voltage_level_in > dsss_pkg::DCB_LEVEL_MAX ?
		dsss_pkg::DCB_LEVEL_MAX : dc_brake_voltage_level_in; // [RL19]

	// ==========================================================
	// Target and ramp set selection
	logic [12:0] set_c;
	logic [1:0]  ramp_sel;
	logic        key_halt;
	assign set_c = set_frequency_in > top_f ? top_f :
		set_frequency_in < launch_c ? launch_c : set_frequency_in;
	assign ramp_sel = jog_s ? dsss_pkg::RAMP_SET_FOUR : // [RL4]
		step_seq_active_in ? step_seq_ramp_sel_in : // [RL2]
		terminal_ramp_sel_in != dsss_pkg::RAMP_SET_ONE ? terminal_ramp_sel_in : // [RL2]
		dsss_pkg::RAMP_SET_ONE; // [RL3]
	assign key_halt = panel_halt_key_enable_in && key_s &&
		(command_source_select_in == dsss_pkg::SRC_TERMINAL ||
		command_source_select_in == dsss_pkg::SRC_COMM); // [RL6]

	// ==========================================================
	// Ramp stepper
	dsss_ramp_if rp ();
	dsss_ramp u_ramp (
		.core_clk_in (core_clk_in),
		.resetn_in   (resetn_in),
		.rp          (rp.ramp)
	);

	// ==========================================================
	// Sequencer
	dsss_pkg::dsss_state_t st_q, st_d;
	logic [31:0] cnt_q, cnt_d;
	logic [31:0] tenth_q, tenth_d;
	logic        lock_q, lock_d;
	logic [12:0] tgt_d;
	logic        load_d, fast_d;
	logic [12:0] loadv_d;
	logic        go;
	logic        tick10;

	assign go     = run_s && !lock_q;
	assign tick10 = (tenth_q + 32'h1 >= TENTH_CYC);
	assign tenth_d = tick10 ? 32'h0 : tenth_q + 32'h1;

	always_comb begin
		st_d    = st_q;
		cnt_d   = tick10 ? cnt_q + 32'h1 : cnt_q;
		lock_d  = lock_q && run_s; // [RL7]
		tgt_d   = set_c;
		load_d  = 1'b0;
		loadv_d = 13'h0;
		fast_d  = 1'b0;
		case (st_q)
			dsss_pkg::DSSS_IDLE: begin
				tgt_d = 13'h0;
				cnt_d = 32'h0;
				if (go && !key_halt) begin
					load_d = 1'b1;
					if (start_method_in) begin
						st_d = dsss_pkg::DSSS_TRACK; // [RL9]
						loadv_d = set_c;
					end else if (start_dc_brake_time_in != 8'h0) begin
						st_d = dsss_pkg::DSSS_START_DCB; // [RL8] [RL17]
					end else begin
						st_d = dsss_pkg::DSSS_RUN; // [RL8]
						loadv_d = launch_c;
					end
				end
			end
			dsss_pkg::DSSS_START_DCB: begin
				tgt_d = 13'h0;
				if (cnt_q >= 32'(start_dc_brake_time_in)) begin
					st_d = dsss_pkg::DSSS_RUN; // [RL8]
					load_d = 1'b1;
					loadv_d = launch_c;
				end
			end
			dsss_pkg::DSSS_TRACK: begin
				fast_d = 1'b1; // [RL9]
				tgt_d = 13'h0;
				if (ihigh_s && rp.freq > 13'h0) begin
					cnt_d = cnt_q; // [RL12]
				end else if (ihigh_s || cnt_q >= 32'(track_t)) begin
					st_d = dsss_pkg::DSSS_RUN; // [RL10]
				end
				if (ihigh_s) tgt_d = 13'h0; // [RL12]
				else tgt_d = (cnt_q >= 32'(track_t)) ? rp.freq : 13'h0;
			end
			dsss_pkg::DSSS_RUN: begin
				if (!run_s || key_halt) begin
					cnt_d = 32'h0;
					if (halt_method_in) begin
						st_d = dsss_pkg::DSSS_IDLE; // [RL14]
						load_d = 1'b1;
					end else begin
						st_d = dsss_pkg::DSSS_DECEL; // [RL13]
					end
				end
			end
			dsss_pkg::DSSS_DECEL: begin
				tgt_d = halt_f; // [RL16]
				cnt_d = 32'h0;
				if (rp.freq <= halt_f) begin
					load_d = 1'b1;
					if (halt_dc_brake_time_in != 8'h0) st_d = dsss_pkg::DSSS_HALT_DCB; // [RL13] [RL18]
					else st_d = dsss_pkg::DSSS_IDLE; // [RL13]
				end
			end
			dsss_pkg::DSSS_HALT_DCB: begin
				tgt_d = 13'h0;
				if (cnt_q >= 32'(halt_dc_brake_time_in)) st_d = dsss_pkg::DSSS_IDLE;
			end
			default: st_d = dsss_pkg::DSSS_IDLE;
		endcase
		if (key_halt && run_s && st_q != dsss_pkg::DSSS_IDLE) lock_d = 1'b1; // [RL7]
	end

	assign rp.ramp_time  = ramp_time_set_in[ramp_sel]; // [RL1]
	assign rp.full_scale = top_f;
	assign rp.target     = tgt_d;
	assign rp.load       = load_d;
	assign rp.load_value = loadv_d;
	assign rp.fast       = fast_d;

	always_ff @(posedge core_clk_in) begin
		if (!resetn_in) begin
			st_q    <= dsss_pkg::DSSS_IDLE;
			cnt_q   <= 32'h0;
			tenth_q <= 32'h0;
			lock_q  <= 1'b0;
		end else begin
			st_q    <= st_d;
			cnt_q   <= cnt_d;
			tenth_q <= tenth_d;
			lock_q  <= lock_d;
		end
	end

	// ==========================================================
	// Registered outputs
	logic drive_on, brake_on;
	assign drive_on = (st_q == dsss_pkg::DSSS_RUN) || (st_q == dsss_pkg::DSSS_TRACK) ||
		(st_q == dsss_pkg::DSSS_DECEL);
	assign brake_on = (st_q == dsss_pkg::DSSS_START_DCB) || (st_q == dsss_pkg::DSSS_HALT_DCB); // [RL14]

	always_ff @(posedge core_clk_in) begin
		if (!resetn_in) begin
			out_frequency_out       <= 13'h0;
			out_enable_out          <= 1'b0;
			reverse_out             <= 1'b0;
			dc_brake_out            <= 1'b0;
			dc_brake_level_out      <= dsss_pkg::DCB_LEVEL_RST;
			track_current_limit_out <= dsss_pkg::TRACK_ILIM_RST;
			ramp_set_out            <= dsss_pkg::RAMP_SET_ONE;
			running_out             <= 1'b0;
		end else begin
			out_frequency_out       <= drive_on ? rp.freq : 13'h0;
			out_enable_out          <= drive_on;
			reverse_out             <= rev_s && reverse_permit_in; // [RL5]
			dc_brake_out            <= brake_on; // [RL19]
			dc_brake_level_out      <= dcb_lvl; // [RL19]
			track_current_limit_out <= ilim; // [RL11]
			ramp_set_out            <= ramp_sel; // [RL1]
			running_out             <= st_q != dsss_pkg::DSSS_IDLE;
		end
	end
endmodule : dsss_sequencer
`default_nettype wire

// [verif/dsss_seq_assertions.sv]
/* Port checks of the start/stop sequencer.
   Assumes bind to dsss_sequencer, static configuration while running. */
`timescale 1ns/10ps
`default_nettype none
module dsss_seq_assertions (
	// Clock, reset and inputs
	input wire logic        core_clk_in,
	input wire logic        resetn_in,
	input wire logic        jog_in,
	input wire logic        reverse_permit_in,
	input wire logic        start_method_in,
	input wire logic        halt_method_in,
	input wire logic [12:0] launch_frequency_in,
	input wire logic [7:0]  dc_brake_voltage_level_in,
	input wire logic [7:0]  track_current_limit_in,
	input wire logic [12:0] set_frequency_in,
	// Outputs
	input wire logic [12:0] out_frequency_out,
	input wire logic        out_enable_out,
	input wire logic        reverse_out,
	input wire logic        dc_brake_out,
	input wire logic [7:0]  dc_brake_level_out,
	input wire logic [7:0]  track_current_limit_out,
	input wire logic [1:0]  ramp_set_out
);
	// ====================
	// Properties
	default clocking @(posedge core_clk_in); endclocking
	default disable iff (!resetn_in);
	sequence drive_s;
		out_enable_out && !dc_brake_out;
	endsequence
	sequence step_s;
		drive_s ##1 drive_s;
	endsequence
	jog_ramp_a: assert property (jog_in [*5] |-> ramp_set_out == 2'h3)
		else $error("jog ramp set wrong");
	rev_block_a: assert property (!reverse_permit_in [*4] |-> !reverse_out)
		else $error("reverse while refused");
	launch_start_a: assert property ($rose(out_enable_out) && !start_method_in && !dc_brake_out
		|-> out_frequency_out == launch_frequency_in) else $error("start not at launch");
	track_start_a: assert property ($rose(out_enable_out) && start_method_in
		|-> out_frequency_out == set_frequency_in) else $error("track not from set");
	ilim_out_a: assert property ($stable(track_current_limit_in) [*4] |-> track_current_limit_out ==
		((track_current_limit_in > 8'hc8) ? 8'hc8 : track_current_limit_in)) else $error("limit wrong");
	coast_nobrake_a: assert property ((halt_method_in && start_method_in) [*2] |-> !dc_brake_out)
		else $error("brake in coast mode");
	off_zero_a: assert property (!out_enable_out |-> out_frequency_out == 13'h0000)
		else $error("frequency while off");
	brake_level_a: assert property (dc_brake_out |-> dc_brake_level_out ==
		((dc_brake_voltage_level_in > 8'hc8) ? 8'hc8 : dc_brake_voltage_level_in)) else $error("level wrong");
	ramp_step_a: assert property (step_s |-> (out_frequency_out - $past(out_frequency_out))
		inside {13'h0000, 13'h0001, 13'h1fff}) else $error("frequency jump");
endmodule : dsss_seq_assertions
bind dsss_sequencer dsss_seq_assertions u_chk (.*);
`default_nettype wire

// [verif/dsss_motor_model.sv]
/* Motor and power stage: shaft speed lags the output frequency.
   Assumes the sequencer's clock; current is high when slip is large. */
`timescale 1ns/10ps
`default_nettype none
module dsss_motor_model #(
	parameter logic [12:0] SPD0 = 13'h0006
) (
	// Clock and drive
	input  wire logic        core_clk_in,
	input  wire logic [12:0] freq_in,
	input  wire logic        enable_in,
	input  wire logic        brake_in,
	// Current comparator
	output var  logic        current_high_out
);
	// ====================
	// Shaft speed
	logic [12:0] spd_q = SPD0;
	logic [4:0]  div_q = 5'h00;
	always @(posedge core_clk_in) begin
		div_q <= div_q + 5'h01;
		if (brake_in)
			spd_q <= 13'h0000;
		else if (enable_in && div_q == 5'h00 && spd_q != freq_in)
			spd_q <= (spd_q < freq_in) ? spd_q + 13'h0001 : spd_q - 13'h0001;
	end
	assign current_high_out = enable_in && (freq_in > spd_q + 13'h0002);
endmodule : dsss_motor_model
`default_nettype wire

// [verif/test_drive_start_stop_sequencer.sv]
/* Self-checking bench of the start/stop sequencer.
   Assumes the motor model on the current input, short tenth-second count. */
`timescale 1ns/10ps
`default_nettype none
module test_drive_start_stop_sequencer;
	// ====================
	// Stimulus and outputs
	logic core_clk_in = 1'b0, resetn_in = 1'b0, current_high_in;
	logic run_cmd_in = 1'b0, reverse_req_in = 1'b0, jog_in = 1'b0, panel_halt_key_in = 1'b0;
	logic reverse_permit_in = 1'b1, panel_halt_key_enable_in = 1'b1, step_seq_active_in = 1'b0;
	logic start_method_in = 1'b0, halt_method_in = 1'b0;
	logic [1:0]  command_source_select_in = 2'h1, terminal_ramp_sel_in = 2'h0, step_seq_ramp_sel_in = 2'h2;
	logic [12:0] launch_frequency_in = 13'h0005, halt_frequency_in = 13'h0005, set_frequency_in = 13'h0008;
	logic [12:0] max_frequency_in = 13'h1fff, upper_limit_in = 13'h1fff;
	logic [7:0]  start_dc_brake_time_in = 8'h01, halt_dc_brake_time_in = 8'h01;
	logic [7:0]  dc_brake_voltage_level_in = 8'hd2, track_duration_in = 8'h01, track_current_limit_in = 8'hd2;
	logic [15:0] ramp_time_set_in [4] = '{16'h0001, 16'h0001, 16'h0001, 16'h0001};
	logic [12:0] out_frequency_out;
	logic [7:0]  dc_brake_level_out, track_current_limit_out;
	logic [1:0]  ramp_set_out;
	logic        out_enable_out, reverse_out, dc_brake_out, running_out;
	int          n_mismatch = 0, n_checks = 0, cyc = 0;

	dsss_sequencer #(.TENTH_CYC(10)) dut (.*);
	dsss_motor_model u_motor (.core_clk_in, .freq_in(out_frequency_out), .enable_in(out_enable_out),
		.brake_in(dc_brake_out), .current_high_out(current_high_in));

	initial forever #20 core_clk_in = ~core_clk_in;

	// ====================
	// Tasks
	task automatic chk(input logic [12:0] got, input logic [12:0] exp);
		n_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("FAIL %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic wt(ref logic s, input logic v, input int lim);
		for (int k = 0; k < lim && s !== v; k++) @(negedge core_clk_in);
		chk(s, v);
	endtask : wt
	task automatic wtf(input logic [12:0] v, input int lim);
		for (int k = 0; k < lim && out_frequency_out !== v; k++) @(negedge core_clk_in);
		chk(out_frequency_out, v);
	endtask : wtf
	task automatic finish_test();
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : finish_test

	always @(posedge core_clk_in) begin
		cyc++;
		if (cyc == 60000) begin
			n_mismatch++;
			finish_test();
		end
	end

	// ====================
	// Sequence
	initial begin
		int k;
		repeat (10) @(negedge core_clk_in);
		chk(track_current_limit_out, 13'h0096);
		chk(dc_brake_level_out, 13'h0014);
		chk(ramp_set_out, 13'h0000);
		resetn_in = 1'b1;
		@(negedge core_clk_in);
		repeat (5) @(negedge core_clk_in);
		chk(track_current_limit_out, 13'h00c8);
		run_cmd_in = 1'b1;
		wt(dc_brake_out, 1'b1, 8);
		chk(dc_brake_level_out, 13'h00c8);
		wt(dc_brake_out, 1'b0, 40);
		@(negedge core_clk_in);
		chk(out_frequency_out, launch_frequency_in);
		wtf(set_frequency_in, 2000);
		repeat (700) @(negedge core_clk_in);
		chk(out_frequency_out, set_frequency_in);
		run_cmd_in = 1'b0;
		wtf(halt_frequency_in, 2000);
		wt(dc_brake_out, 1'b1, 20);
		wt(running_out, 1'b0, 40);
		chk(out_enable_out, 13'h0000);
		halt_method_in = 1'b1;
		start_dc_brake_time_in = 8'h00;
		run_cmd_in = 1'b1;
		wt(running_out, 1'b1, 8);
		chk(out_frequency_out, launch_frequency_in);
		run_cmd_in = 1'b0;
		wt(running_out, 1'b0, 6);
		chk(dc_brake_out, 13'h0000);
		for (int i = 0; i < 3; i++) begin
			{panel_halt_key_enable_in, command_source_select_in} = (i == 0) ? 3'h1 : (i == 1) ? 3'h5 : 3'h4;
			repeat (4) @(negedge core_clk_in);
			run_cmd_in = 1'b1;
			wt(running_out, 1'b1, 8);
			panel_halt_key_in = 1'b1;
			repeat (10) @(negedge core_clk_in);
			chk(running_out, (i == 1) ? 1'b0 : 1'b1);
			panel_halt_key_in = 1'b0;
			repeat (20) @(negedge core_clk_in);
			chk(running_out, (i == 1) ? 1'b0 : 1'b1);
			run_cmd_in = 1'b0;
			wt(running_out, 1'b0, 8);
		end
		reverse_req_in = 1'b1;
		reverse_permit_in = 1'b0;
		repeat (5) @(negedge core_clk_in);
		chk(reverse_out, 13'h0000);
		reverse_permit_in = 1'b1;
		repeat (5) @(negedge core_clk_in);
		chk(reverse_out, 13'h0001);
		for (int i = 0; i < 5; i++) begin
			{jog_in, step_seq_active_in, terminal_ramp_sel_in} = 4'((i == 3) ? 8 : (i == 2) ? 4 : i % 4);
			repeat (5) @(negedge core_clk_in);
			chk(ramp_set_out, 13'(i % 4));
		end
		start_method_in = 1'b1;
		start_dc_brake_time_in = 8'h03;
		run_cmd_in = 1'b1;
		wt(running_out, 1'b1, 8);
		chk(dc_brake_out, 13'h0000);
		for (k = 0; k < 100 && out_frequency_out >= set_frequency_in; k++) @(negedge core_clk_in);
		chk(13'(out_frequency_out < set_frequency_in), 13'h0001);
		wtf(set_frequency_in, 3000);
		finish_test();
	end
endmodule : test_drive_start_stop_sequencer
`default_nettype wire
